// ==== hdl/event_sync.sv ====
// Synchroniser for card-side toggles and levels into the system clock
`timescale 1ns/1ps
module event_sync import irq_wake_pkg::*; (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Card-domain inputs
    input  wire logic [SYNC_W-1:0] async_in,
    // Synchronised outputs
    output logic      [SYNC_W-1:0] level,
    output logic      [SYNC_W-1:0] change
);

    sync_s r;
    sync_s next_r;

    // Stage one feeds only stage two; edges are judged on later stages
    always_comb begin
        next_r    = r;
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Toggle edges give exactly one pulse per card event
    assign level  = r.s2;
    assign change = r.s2 ^ r.s3;

endmodule : event_sync

// ==== hdl/host_interrupt_wakeup_logic.sv ====
// Interrupt, wakeup, block buffer and transfer sequencer of the card host
`timescale 1ns/1ps
// Operation
// - Enabled event sources latch into normal or error status flags.
// - Clearing a status enable clears its flag; masked sources never signal.
// - Interrupt asserts when any flag and its signal enable are both set.
// - Writing one clears a status flag; writing zero leaves it.
// - Card flag ignores write-one and follows the card request level.
// - Wake control lets card, insert and remove flags drive wakeup.
// - Wakeup needs status enable, wake enable and flag together.
// - Slot summary bit reads interrupt ORed with wakeup.
// - Interrupt and wakeup polarity is selectable.
// - Status is held in the system clock domain, stable while read.
// - Transfer start reaches the card side as a synchronised toggle.
// - Transfer data crosses sides only through the block buffer.
// - Done flag for DMA and non-DMA; buffer flags only non-DMA.
// - Read done only once the last block sits in the buffer.
// - Write done only after last block sent and card busy ends.
// - Buffer holds at least 512 bytes, one block.
// - Buffer holds 512 bytes times blocks per flow unit.
// - Write space falls at block end and rises for the next block.
module host_interrupt_wakeup_logic import irq_wake_pkg::*; #(
    parameter int BLOCKS_PER_FLOW_UNIT = 1,
    parameter bit IRQ_ACTIVE_LOW       = 1'b0
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Card-domain event inputs
    input  wire logic              ins_toggle,
    input  wire logic              rem_toggle,
    input  wire logic [NB_ERR-1:0] err_toggle,
    input  wire logic              card_irq_req,
    input  wire logic              card_busy,
    // Card-side word port, read direction into the buffer
    input  wire logic              cw_valid,
    input  wire logic [31:0]       cw_data,
    output logic                   cw_ready,
    // Card-side word port, write direction out of the buffer
    output logic                   cr_valid,
    output logic      [31:0]       cr_data,
    input  wire logic              cr_ready,
    // Transfer control toward the card clock domain
    output logic                   start_toggle,
    output logic                   xfer_read,
    // System signalling
    output logic                   sys_irq,
    output logic                   sys_wake
);

    // Buffer sized for a full flow unit of 512-byte blocks
    localparam int BUF_WORDS = BLOCK_BYTES * BLOCKS_PER_FLOW_UNIT / 4;
    localparam int PTR_W     = $clog2(BUF_WORDS) + 1;
    localparam int LEN_W     = $clog2(BUF_WORDS * 4) + 1;

    typedef struct packed {
        xfer_e              st;
        logic [NB_NORM-1:0] nstat;
        logic [NB_ERR-1:0]  estat;
        logic [NB_NORM-1:0] nen;
        logic [NB_ERR-1:0]  een;
        logic [NB_NORM-1:0] nsig;
        logic [NB_ERR-1:0]  esig;
        logic [NB_WAKE-1:0] wake;
        logic [LEN_W-1:0]   blen;
        logic [CNT_W-1:0]   bcnt;
        logic [CNT_W-1:0]   left;
        logic               dir_rd;
        logic               dma;
        logic [PTR_W-1:0]   ptr;
        logic [PTR_W-1:0]   cptr;
        logic               start_tog;
        logic [31:0]        rdata;
        logic               slverr;
    } regs_s;

    regs_s              r;
    regs_s              next_r;
    logic [31:0]        mem [BUF_WORDS];
    logic               mem_we;
    logic [PTR_W-1:0]   mem_wa;
    logic [31:0]        mem_wd;
    logic [SYNC_W-1:0]  s_lvl;
    logic [SYNC_W-1:0]  s_chg;
    logic               card_lvl;
    logic               busy_lvl;
    logic               irq_raw;
    logic               wake_raw;
    logic [NB_WAKE-1:0] wake_src;
    logic [PTR_W-1:0]   bwords;
    logic               setup;
    logic               wr;
    logic               rd;
    logic [31:0]        wmask;

    // Card-domain events enter through the synchroniser
    event_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({card_busy, card_irq_req, err_toggle, rem_toggle, ins_toggle}),
        .level    (s_lvl),
        .change   (s_chg)
    );

    // Signalling paths and derived values
    assign card_lvl = s_lvl[S_CARD];
    assign busy_lvl = s_lvl[S_BUSY];
    assign wake_src = {r.nstat[N_REM], r.nstat[N_INS], r.nstat[N_CARD]};
    assign irq_raw  = |(r.nstat & r.nsig) | |(r.estat & r.esig);
    assign wake_raw = |(wake_src & r.wake);
    assign sys_irq  = irq_raw ^ IRQ_ACTIVE_LOW;
    assign sys_wake = wake_raw ^ IRQ_ACTIVE_LOW;
    assign bwords   = PTR_W'(r.blen[LEN_W-1:2]) + PTR_W'(|r.blen[1:0]);
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite;
    assign rd       = psel & penable & ~pwrite;
    assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Bus answers: one access cycle, data captured in the setup cycle
    assign pready       = 1'b1;
    assign prdata       = r.rdata;
    assign pslverr      = r.slverr;
    assign start_toggle = r.start_tog;
    assign xfer_read    = r.dir_rd;
    assign cw_ready     = (r.st == ST_RD_FILL);
    assign cr_valid     = (r.st == ST_WR_DRAIN);
    assign cr_data      = mem[r.cptr[PTR_W-2:0]];

    always_comb begin
        logic [NB_NORM-1:0] nevt;
        logic [NB_NORM-1:0] nclr;
        logic [NB_ERR-1:0]  eclr;
        logic               map_hit;
        nevt    = '0;
        nclr    = '0;
        eclr    = '0;
        map_hit = 1'b1;
        next_r  = r;
        mem_we  = 1'b0;
        mem_wa  = r.ptr;
        mem_wd  = pwdata;

        // Read data and error captured in setup, stable through access
        if (setup) begin
            next_r.rdata = '0;
            unique case (paddr)
                OFF_NSTAT:   next_r.rdata = 32'(r.nstat);
                OFF_ESTAT:   next_r.rdata = 32'(r.estat);
                OFF_NEN:     next_r.rdata = 32'(r.nen);
                OFF_EEN:     next_r.rdata = 32'(r.een);
                OFF_NSIG:    next_r.rdata = 32'(r.nsig);
                OFF_ESIG:    next_r.rdata = 32'(r.esig);
                OFF_WAKE:    next_r.rdata = 32'(r.wake);
                OFF_SLOT:    next_r.rdata = 32'({wake_raw, irq_raw, irq_raw | wake_raw});
                OFF_CTRL:    next_r.rdata = 32'({r.dma, r.dir_rd, 1'b0});
                OFF_BLOCK:   next_r.rdata = {r.bcnt, 16'(r.blen)};
                OFF_PRESENT: next_r.rdata = 32'({card_lvl, busy_lvl, r.st != ST_IDLE,
                                                 r.st == ST_RD_EMPTY, r.st == ST_WR_FILL});
                OFF_DATA:    next_r.rdata = (r.st == ST_RD_EMPTY) ?
                                            mem[r.ptr[PTR_W-2:0]] : 32'h0000_0000;
                default:     map_hit = 1'b0;
            endcase
            next_r.slverr = ~map_hit;
        end

        // Transfer sequencer
        unique case (r.st)
            ST_IDLE: begin
                if (wr && paddr == OFF_CTRL && pstrb[0] && pwdata[C_START]) begin
                    next_r.start_tog = ~r.start_tog;
                    next_r.left      = (r.bcnt == '0) ? CNT_W'(1) : r.bcnt;
                    next_r.ptr       = '0;
                    next_r.cptr      = '0;
                    next_r.dir_rd    = pwdata[C_DIRRD];
                    next_r.dma       = pwdata[C_DMA];
                    next_r.st        = pwdata[C_DIRRD] ? ST_RD_FILL : ST_WR_FILL;
                    nevt[N_WRRDY]    = ~pwdata[C_DIRRD] & ~pwdata[C_DMA];
                end
            end
            ST_WR_FILL: begin
                // Words past the block end are never accepted
                if (wr && paddr == OFF_DATA) begin
                    mem_we     = 1'b1;
                    next_r.ptr = r.ptr + PTR_W'(1);
                    if (r.ptr + PTR_W'(1) >= bwords) begin
                        next_r.ptr = '0;
                        next_r.st  = ST_WR_DRAIN;
                    end
                end
            end
            ST_WR_DRAIN: begin
                if (cr_ready) begin
                    next_r.cptr = r.cptr + PTR_W'(1);
                    if (r.cptr + PTR_W'(1) >= bwords) begin
                        next_r.cptr = '0;
                        next_r.left = r.left - CNT_W'(1);
                        if (r.left == CNT_W'(1)) begin
                            next_r.st = ST_WR_BUSY;
                        end else begin
                            next_r.st     = ST_WR_FILL;
                            nevt[N_WRRDY] = ~r.dma;
                        end
                    end
                end
            end
            ST_WR_BUSY: begin
                // Busy is sampled after synchronising, so done trails it
                if (!busy_lvl) begin
                    nevt[N_DONE] = 1'b1;
                    next_r.st    = ST_IDLE;
                end
            end
            ST_RD_FILL: begin
                if (cw_valid) begin
                    mem_we      = 1'b1;
                    mem_wa      = r.cptr;
                    mem_wd      = cw_data;
                    next_r.cptr = r.cptr + PTR_W'(1);
                    if (r.cptr + PTR_W'(1) >= bwords) begin
                        next_r.cptr   = '0;
                        next_r.left   = r.left - CNT_W'(1);
                        next_r.st     = ST_RD_EMPTY;
                        nevt[N_RDRDY] = ~r.dma;
                        nevt[N_DONE]  = (r.left == CNT_W'(1));
                    end
                end
            end
            ST_RD_EMPTY: begin
                if (rd && paddr == OFF_DATA) begin
                    next_r.ptr = r.ptr + PTR_W'(1);
                    if (r.ptr + PTR_W'(1) >= bwords) begin
                        next_r.ptr = '0;
                        next_r.st  = (r.left == '0) ? ST_IDLE : ST_RD_FILL;
                    end
                end
            end
        endcase

        // Abort returns to idle from any transfer state
        if (wr && paddr == OFF_CTRL && pstrb[0] && pwdata[C_ABORT]) begin
            next_r.st = ST_IDLE;
        end

        // Card events after synchronisation
        nevt[N_INS] = s_chg[S_INS];
        nevt[N_REM] = s_chg[S_REM];

        // Register writes
        if (wr) begin
            unique case (paddr)
                OFF_NSTAT: nclr = NB_NORM'(pwdata & wmask);
                OFF_ESTAT: eclr = NB_ERR'(pwdata & wmask);
                OFF_NEN:   next_r.nen  = NB_NORM'((32'(r.nen) & ~wmask) | (pwdata & wmask));
                OFF_EEN:   next_r.een  = NB_ERR'((32'(r.een) & ~wmask) | (pwdata & wmask));
                OFF_NSIG:  next_r.nsig = NB_NORM'((32'(r.nsig) & ~wmask) | (pwdata & wmask));
                OFF_ESIG:  next_r.esig = NB_ERR'((32'(r.esig) & ~wmask) | (pwdata & wmask));
                OFF_WAKE:  next_r.wake = NB_WAKE'((32'(r.wake) & ~wmask) | (pwdata & wmask));
                OFF_BLOCK: begin
                    if (r.st == ST_IDLE) begin
                        next_r.blen = LEN_W'((32'(r.blen) & ~wmask) | (pwdata & wmask));
                        next_r.bcnt = CNT_W'((({r.bcnt, 16'h0000} & ~wmask)
                                              | (pwdata & wmask)) >> BCNT_LSB);
                    end
                end
                default: ;
            endcase
        end
        nclr[N_CARD] = 1'b0;

        // Flags: set beats clear, then gated by the new enables
        next_r.nstat = ((r.nstat & ~nclr) | (nevt & r.nen)) & next_r.nen;
        next_r.estat = ((r.estat & ~eclr) | (s_chg[S_ERR +: NB_ERR] & r.een))
                       & next_r.een;
        next_r.nstat[N_CARD] = card_lvl & next_r.nen[N_CARD];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r      <= '0;
            r.st   <= ST_IDLE;
            r.blen <= LEN_W'(BLOCK_LEN_RST);
            r.bcnt <= BCNT_RST;
        end else begin
            r <= next_r;
        end
    end

    // Buffer storage needs no reset; contents are defined by pointers
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_wa[PTR_W-2:0]] <= mem_wd;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    flag_latch_a: assert property (s_chg[S_INS] && r.nen[N_INS]
        && !(wr && paddr == OFF_NEN) |=> r.nstat[N_INS])
        else $error("insertion event lost");
    mask_clear_a: assert property ((r.nstat & ~r.nen) == '0 && (r.estat & ~r.een) == '0)
        else $error("flag set while its enable is clear");
    irq_drive_a: assert property (r.nstat[N_REM] && r.nsig[N_REM]
        |-> sys_irq == !IRQ_ACTIVE_LOW)
        else $error("interrupt not asserted for enabled flag");
    w1c_clear_a: assert property (wr && paddr == OFF_NSTAT && pstrb[0] && pwdata[N_INS]
        && !s_chg[S_INS] |=> !r.nstat[N_INS])
        else $error("write-one did not clear flag");
    card_hold_a: assert property (card_lvl && r.nen[N_CARD]
        && !(wr && paddr == OFF_NEN) |=> r.nstat[N_CARD])
        else $error("card flag dropped while requested");
    wake_gate_a: assert property (wake_raw == 1'b0 || (r.nen[N_INS] && r.wake[W_INS]
        && r.nstat[N_INS]) || (r.nen[N_REM] && r.wake[W_REM] && r.nstat[N_REM])
        || (r.nen[N_CARD] && r.wake[W_CARD] && r.nstat[N_CARD]))
        else $error("wakeup without enabled cause");
    slot_sum_a: assert property (setup && paddr == OFF_SLOT
        |=> prdata[0] == $past(irq_raw || wake_raw) ##1 pready)
        else $error("slot summary mismatch");
    start_tog_a: assert property (r.st == ST_IDLE && wr && paddr == OFF_CTRL
        && pstrb[0] && pwdata[C_START] |=> start_toggle != $past(start_toggle))
        else $error("start not passed to card side");
    space_fall_a: assert property (r.st == ST_WR_FILL && wr && paddr == OFF_DATA
        && r.ptr + PTR_W'(1) >= bwords |=> r.st == ST_WR_DRAIN && !cw_ready)
        else $error("write space did not fall at block end");
    wr_done_a: assert property (r.st == ST_WR_BUSY && !busy_lvl && r.nen[N_DONE]
        && !(wr && paddr == OFF_NEN) |=> r.nstat[N_DONE] && r.st == ST_IDLE)
        else $error("write done missing after busy end");

    wr_xfer_c: cover property (r.st == ST_WR_BUSY ##[1:300] r.st == ST_IDLE);
    rd_xfer_c: cover property (r.st == ST_RD_EMPTY && r.left == '0 ##[1:300] r.st == ST_IDLE);
    wake_c:    cover property (wake_raw && !irq_raw);
    card_c:    cover property (r.nstat[N_CARD] && irq_raw);

endmodule : host_interrupt_wakeup_logic

// ==== hdl/irq_wake_pkg.sv ====
// Shared constants and types for the host interrupt, wakeup and transfer block
package irq_wake_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_NSTAT   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ESTAT   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_NEN     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EEN     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_NSIG    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ESIG    = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_WAKE    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_SLOT    = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_BLOCK   = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_PRESENT = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_DATA    = 8'h2C;

    // Normal status field positions
    localparam int NB_NORM = 6;
    localparam int N_DONE  = 0;
    localparam int N_WRRDY = 1;
    localparam int N_RDRDY = 2;
    localparam int N_INS   = 3;
    localparam int N_REM   = 4;
    localparam int N_CARD  = 5;

    // Error status and wake control widths and positions
    localparam int NB_ERR  = 4;
    localparam int NB_WAKE = 3;
    localparam int W_CARD  = 0;
    localparam int W_INS   = 1;
    localparam int W_REM   = 2;

    // Control and block-count field positions
    localparam int C_START  = 0;
    localparam int C_DIRRD  = 1;
    localparam int C_DMA    = 2;
    localparam int C_ABORT  = 3;
    localparam int BCNT_LSB = 16;

    // Synchroniser lanes
    localparam int SYNC_W = 8;
    localparam int S_INS  = 0;
    localparam int S_REM  = 1;
    localparam int S_ERR  = 2;
    localparam int S_CARD = 6;
    localparam int S_BUSY = 7;

    // Block geometry and reset values
    localparam int          BLOCK_BYTES   = 512;
    localparam int          CNT_W         = 16;
    localparam logic [15:0] BLOCK_LEN_RST = 16'h0200;
    localparam logic [15:0] BCNT_RST      = 16'h0001;

    // Transfer sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE     = 6'h01,
        ST_WR_FILL  = 6'h02,
        ST_WR_DRAIN = 6'h04,
        ST_WR_BUSY  = 6'h08,
        ST_RD_FILL  = 6'h10,
        ST_RD_EMPTY = 6'h20
    } xfer_e;

    // Two-stage synchroniser plus edge history
    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
    } sync_s;

endpackage : irq_wake_pkg

// ==== tb/card_model.sv ====
// Card-side partner: event sources, busy level and word ports
`timescale 1ns/1ps
module card_model (
    // Clock
    input  wire logic        pclk,
    // Words toward the buffer
    input  wire logic        cw_ready,
    output logic             cw_valid,
    output logic [31:0]      cw_data,
    // Words out of the buffer
    input  wire logic        cr_valid,
    input  wire logic [31:0] cr_data,
    output logic             cr_ready,
    // Events and levels
    output logic             ins_toggle,
    output logic             rem_toggle,
    output logic [3:0]       err_toggle,
    output logic             card_irq_req,
    output logic             card_busy
);
    logic [31:0] tx_q[$];
    logic [31:0] rx_q[$];
    int          busy_cnt = 0;
    int          vcnt = 0;

    initial begin
        {ins_toggle, rem_toggle, err_toggle, card_irq_req} = '0;
        {cw_valid, cr_ready, card_busy} = '0;
        cw_data = 32'h0;
    end

    // Each change of a toggle is one event
    task automatic ev_ins();
        ins_toggle <= ~ins_toggle;
    endtask : ev_ins
    task automatic ev_err(input int i);
        err_toggle[i] <= ~err_toggle[i];
    endtask : ev_err

    // Busy rises with the first offered word so it is seen before the last one
    always @(posedge pclk) begin
        vcnt <= cr_valid ? vcnt + 1 : 0;
        busy_cnt <= cr_valid ? 10 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
        card_busy <= cr_valid || busy_cnt > 1;
        cr_ready <= cr_valid && vcnt >= 3 && $urandom_range(1) == 1;
        if (cr_valid && cr_ready) begin
            rx_q.push_back(cr_data);
        end
        if (cw_valid && cw_ready) begin
            void'(tx_q.pop_front());
        end
        // Idle data inverts every cycle, alternating between the inverse of the last word and the word itself
        cw_valid <= tx_q.size() != 0;
        cw_data <= tx_q.size() != 0 ? tx_q[0] : ~cw_data;
    end
endmodule : card_model

// ==== tb/testbench.sv ====
// Self-checking bench for the interrupt, wakeup and transfer block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench import irq_wake_pkg::*;;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err_s;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, cw_data, cr_data;
    logic [3:0]        pstrb, err_toggle;
    logic              ins_toggle, rem_toggle, card_irq_req, card_busy, s;
    logic              cw_valid, cw_ready, cr_valid, cr_ready;
    logic              start_toggle, xfer_read, sys_irq, sys_wake;
    logic [31:0]       wd[2];
    int                num_errors = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                e;

    host_interrupt_wakeup_logic uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .ins_toggle, .rem_toggle, .err_toggle,
        .card_irq_req, .card_busy, .cw_valid, .cw_data, .cw_ready, .cr_valid, .cr_data,
        .cr_ready, .start_toggle, .xfer_read, .sys_irq, .sys_wake);
    card_model cm (.pclk, .cw_ready, .cw_valid, .cw_data, .cr_valid, .cr_data, .cr_ready,
        .ins_toggle, .rem_toggle, .err_toggle, .card_irq_req, .card_busy);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // One APB transfer, held until pready is sampled high
    // No wait limit here: only the watchdog ends a stalled access
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err_s = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rd, x)
    endtask : rdc
    // Polls a normal status flag; a long wait is a mismatch
    task automatic wait_flag(input int b);
        int n = 0;
        do begin
            apb(1'b0, OFF_NSTAT, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 60);
        `CHK(rd[b], 1'b1)
    endtask : wait_flag

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Watchdog: a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h0, 8'h00, 32'h0, 4'hF};
        e = $urandom(25);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK({sys_irq, sys_wake}, 2'b00)
        rdc(OFF_NSTAT, 32'h0);
        // Enabled insert event latches, signals, clears by write-one
        wr(OFF_NEN, 32'h08);
        wr(OFF_NSIG, 32'h08);
        cm.ev_ins();
        repeat (8) @(posedge pclk);
        rdc(OFF_NSTAT, 32'h08);
        `CHK(sys_irq, 1'b1)
        rdc(OFF_SLOT, 32'h03);
        wr(OFF_NSTAT, 32'h0);
        rdc(OFF_NSTAT, 32'h08);
        wr(OFF_NSTAT, 32'h08);
        rdc(OFF_NSTAT, 32'h0);
        `CHK(sys_irq, 1'b0)
        // Enable cleared drops the flag; masked event never shows
        cm.ev_ins();
        repeat (8) @(posedge pclk);
        rdc(OFF_NSTAT, 32'h08);
        wr(OFF_NEN, 32'h0);
        rdc(OFF_NSTAT, 32'h0);
        cm.ev_ins();
        repeat (8) @(posedge pclk);
        rdc(OFF_NSTAT, 32'h0);
        `CHK(sys_irq, 1'b0)
        $display("test status flags done");
        // Random error source, status only, no signal enable
        e = $urandom_range(3);
        wr(OFF_EEN, 32'hF);
        cm.ev_err(e);
        repeat (8) @(posedge pclk);
        rdc(OFF_ESTAT, 32'h1 << e);
        `CHK(sys_irq, 1'b0)
        wr(OFF_ESTAT, 32'h1 << e);
        rdc(OFF_ESTAT, 32'h0);
        // Card request drives wakeup only, ignores write-one
        wr(OFF_NEN, 32'h20);
        wr(OFF_NSIG, 32'h0);
        wr(OFF_WAKE, 32'h1);
        cm.card_irq_req <= 1'b1;
        repeat (8) @(posedge pclk);
        rdc(OFF_NSTAT, 32'h20);
        `CHK({sys_wake, sys_irq}, 2'b10)
        rdc(OFF_SLOT, 32'h05);
        wr(OFF_NSTAT, 32'h20);
        rdc(OFF_NSTAT, 32'h20);
        wr(OFF_NEN, 32'h0);
        rdc(OFF_NSTAT, 32'h0);
        cm.card_irq_req <= 1'b0;
        repeat (8) @(posedge pclk);
        wr(OFF_NEN, 32'h20);
        rdc(OFF_NSTAT, 32'h0);
        `CHK(sys_wake, 1'b0)
        apb(1'b0, 8'hF0, 32'h0);
        `CHK({err_s, rd}, {1'b1, 32'h0})
        $display("test wakeup done");
        // Non-DMA write of one 8-byte block
        wr(OFF_WAKE, 32'h0);
        wr(OFF_NEN, 32'h07);
        wr(OFF_BLOCK, 32'h0001_0008);
        s = start_toggle;
        wr(OFF_CTRL, 32'h1);
        `CHK(start_toggle, ~s)
        apb(1'b0, OFF_PRESENT, 32'h0);
        `CHK(rd[0], 1'b1)
        wd[0] = $urandom;
        wd[1] = $urandom;
        wr(OFF_DATA, wd[0]);
        wr(OFF_DATA, wd[1]);
        apb(1'b0, OFF_PRESENT, 32'h0);
        `CHK(rd[0], 1'b0)
        wait_flag(N_DONE);
        `CHK(card_busy, 1'b0)
        `CHK({cm.rx_q[0], cm.rx_q[1]}, {wd[0], wd[1]})
        $display("test write done");
        // Read of one block; done only with all words in the buffer
        wr(OFF_NSTAT, 32'h1F);
        cm.tx_q.push_back(wd[1]);
        cm.tx_q.push_back(wd[0]);
        wr(OFF_CTRL, 32'h3);
        `CHK(xfer_read, 1'b1)
        wait_flag(N_RDRDY);
        wait_flag(N_DONE);
        `CHK(cm.tx_q.size(), 0)
        rdc(OFF_DATA, wd[1]);
        rdc(OFF_DATA, wd[0]);
        $display("test read done");
        // DMA read: done still raised, buffer-ready flag stays clear
        wr(OFF_NSTAT, 32'h1F);
        cm.tx_q.push_back(wd[0]);
        cm.tx_q.push_back(wd[1]);
        wr(OFF_CTRL, 32'h7);
        wait_flag(N_DONE);
        rdc(OFF_NSTAT, 32'h01);
        rdc(OFF_DATA, wd[0]);
        rdc(OFF_DATA, wd[1]);
        // Abort of a started write leaves no write space behind
        wr(OFF_CTRL, 32'h1);
        wr(OFF_CTRL, 32'h8);
        rdc(OFF_PRESENT, 32'h0);
        $display("test dma and abort done");
        complete_run();
    end
endmodule : testbench
